// [adc_ctrl_pkg.sv]
// shared constants and types for the conversion controller
package adc_ctrl_pkg;

    // ==========================================================
    // sizes
    localparam int NUM_CH      = 12;
    localparam int CH_W        = 4;
    localparam int RES_W       = 10;
    localparam int LOW_W       = 8;
    localparam int NUM_TIMER   = 3;
    localparam int AVG_MAX     = 8;
    localparam int AVG_SH_W    = 2;
    localparam int IRQ_PERIPH_ID = 19;

    // ==========================================================
    // timing
    localparam int CLK_MHZ       = 100;
    localparam int RATE_KHZ      = 440;
    localparam int CONV_CYCLES   = (CLK_MHZ * 1000) / RATE_KHZ;
    localparam int STARTUP_NS    = 4000;
    localparam int STANDBY_NS    = 400;
    localparam int STARTUP_CYC   = (STARTUP_NS * CLK_MHZ + 999) / 1000;
    localparam int STANDBY_CYC   = (STANDBY_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W         = 10;

    // ==========================================================
    // encodings
    typedef enum logic [1:0] {
        TRG_SOFTWARE = 2'h0,
        TRG_EXT_PIN  = 2'h1,
        TRG_TIMER    = 2'h2,
        TRG_PEN      = 2'h3
    } trig_src_e;

    typedef enum logic [1:0] {
        CMP_LOW     = 2'h0,
        CMP_HIGH    = 2'h1,
        CMP_INSIDE  = 2'h2,
        CMP_OUTSIDE = 2'h3
    } cmp_mode_e;

    typedef enum logic [1:0] {
        PWR_FULL    = 2'h0,
        PWR_SLEEP   = 2'h1,
        PWR_STANDBY = 2'h2
    } pwr_mode_e;

    typedef enum logic [1:0] {
        PANEL_NONE  = 2'h0,
        PANEL_4WIRE = 2'h1,
        PANEL_5WIRE = 2'h2
    } panel_e;

    typedef struct packed {
        trig_src_e              trig_src;
        logic [1:0]             timer_sel;
        logic                   low_res;
        logic                   user_seq;
        pwr_mode_e              pwr_mode;
        cmp_mode_e              cmp_mode;
        logic [RES_W-1:0]       cmp_low;
        logic [RES_W-1:0]       cmp_high;
        panel_e                 panel;
        logic [AVG_SH_W-1:0]    avg_shift;
    } adc_cfg_s;

    typedef struct packed {
        logic                   valid;
        logic [CH_W-1:0]        ch;
        logic [RES_W-1:0]       data;
    } adc_result_s;

endpackage

// [adc_seq_pick.sv]
// sequencer slot picker: next enabled slot at or after a start index
`timescale 1ns/1ns
`default_nettype none
module adc_seq_pick
    import adc_ctrl_pkg::*;
#(
    parameter int SLOTS = NUM_CH
) (
    input  wire logic [SLOTS-1:0]  slot_en_in,
    input  wire logic [CH_W-1:0]   start_in,
    output logic                   found_out,
    output logic [CH_W-1:0]        slot_out
);

    // lowest enabled slot index not below the start index
    always_comb begin
        found_out = 1'b0;
        slot_out  = '0;
        for (int i = SLOTS - 1; i >= 0; i--) begin
            if (slot_en_in[i] && (CH_W'(i) >= start_in)) begin
                found_out = 1'b1;
                slot_out  = CH_W'(i);
            end
        end
    end

endmodule
`default_nettype wire

// [adc_conversion_controller.sv]
// digital conversion controller: triggers, sequencing, results, flags, touch, power
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_controller
    import adc_ctrl_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_CYC,
    parameter int STANDBY_CYCLES = STANDBY_CYC,
    parameter int CONVERT_CYCLES = CONV_CYCLES
) (
    input  wire logic                    clk_in,
    input  wire logic                    reset_n_in,
    input  wire adc_cfg_s                cfg_in,
    input  wire logic                    cfg_we_in,
    input  wire logic                    protect_in,
    input  wire logic [NUM_CH-1:0]       ch_enable_in,
    input  wire logic [NUM_CH-1:0]       digital_sel_in,
    input  wire logic [NUM_CH*CH_W-1:0]  user_seq_in,
    input  wire logic                    sw_start_in,
    input  wire logic                    external_trigger_pin,
    input  wire logic [NUM_TIMER-1:0]    timer_trig_in,
    input  wire logic                    pen_contact_in,
    input  wire logic                    rd_channel_in,
    input  wire logic [CH_W-1:0]         rd_channel_idx_in,
    input  wire logic                    rd_last_in,
    input  wire logic                    rd_status_in,
    input  wire logic                    cell_done_in,
    input  wire logic [RES_W-1:0]        cell_data_in,
    output logic                         cell_start_out,
    output logic [CH_W-1:0]              mux_sel_out,
    output logic                         mux_route_out,
    output logic                         cell_power_out,
    output logic                         cell_bias_out,
    output logic [RES_W-1:0]             last_result_out,
    output logic [CH_W-1:0]              last_channel_out,
    output logic [NUM_CH*RES_W-1:0]      channel_result_out,
    output logic [NUM_CH-1:0]            eoc_out,
    output logic                         result_ready_flag,
    output logic                         global_overrun_flag,
    output logic                         compare_hit_out,
    output logic [RES_W-1:0]             touch_avg_out,
    output logic                         touch_valid_out,
    output logic                         busy_out,
    output logic                         irq_out
);

    // ==========================================================
    // state
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_WAKE  = 5'b00010,
        ST_PICK  = 5'b00100,
        ST_CONV  = 5'b01000,
        ST_DONE  = 5'b10000
    } seq_state_e;

    seq_state_e          state_q, state_d;
    adc_cfg_s            cfg_q;
    logic [2:0]          trig_sync_q;
    logic [CH_W-1:0]     slot_q;
    logic [CH_W-1:0]     cur_ch_q;
    logic [CNT_W-1:0]    cnt_q;
    logic [RES_W-1:0]    chan_q [NUM_CH];
    logic [NUM_CH-1:0]   eoc_q;
    logic                ready_q;
    logic                ovr_q;
    logic [RES_W-1:0]    last_q;
    logic [CH_W-1:0]     last_ch_q;
    logic                hit_q;
    logic [RES_W+2:0]    acc_q;
    logic [3:0]          acc_n_q;
    logic [RES_W-1:0]    tavg_q;
    logic                tvalid_q;

    // ==========================================================
    // configuration with write protection
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cfg_q <= '0;
        end else if (cfg_we_in && !protect_in) begin
            cfg_q <= cfg_in;
        end
    end

    // ==========================================================
    // trigger selection
    // pin sampled twice before any logic reads it
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            trig_sync_q <= '0;
        end else begin
            trig_sync_q <= {trig_sync_q[1:0], external_trigger_pin};
        end
    end

    wire pin_rise = trig_sync_q[1] && !trig_sync_q[2];
    // a timer select beyond the last timer line falls back to timer line 0
    logic [NUM_TIMER-1:0] tmr_q;
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= timer_trig_in;
        end
    end
    wire [1:0] tsel      = (cfg_q.timer_sel < 2'(NUM_TIMER)) ? cfg_q.timer_sel : 2'h0;
    wire       tmr_rise  = timer_trig_in[tsel] && !tmr_q[tsel];
    logic [2:0] pen_sync_q;
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            pen_sync_q <= '0;
        end else begin
            pen_sync_q <= {pen_sync_q[1:0], pen_contact_in};
        end
    end
    wire pen_rise = pen_sync_q[1] && !pen_sync_q[2];

    logic trig_hit;
    always_comb begin
        unique case (cfg_q.trig_src)
            TRG_SOFTWARE: trig_hit = sw_start_in;
            TRG_EXT_PIN:  trig_hit = pin_rise || sw_start_in;
            TRG_TIMER:    trig_hit = tmr_rise || sw_start_in;
            TRG_PEN:      trig_hit = pen_rise || sw_start_in;
            default:      trig_hit = 1'b0;
        endcase
    end

    // ==========================================================
    // sequencer slot choice
    // a slot is live only if the channel of the same index is enabled and not taken by digital use
    wire [NUM_CH-1:0] ch_live = ch_enable_in & ~digital_sel_in;

    function automatic logic [CH_W-1:0] slot_channel(input logic [CH_W-1:0] s,
                                                     input logic use_user,
                                                     input logic [NUM_CH*CH_W-1:0] tbl);
        slot_channel = use_user ? tbl[s*CH_W +: CH_W] : s;
    endfunction

    logic              pick_found;
    logic [CH_W-1:0]   pick_slot;
    adc_seq_pick #(
        .SLOTS (NUM_CH)
    ) u_pick (
        .slot_en_in (ch_live),
        .start_in   (slot_q),
        .found_out  (pick_found),
        .slot_out   (pick_slot)
    );

    wire [CH_W-1:0] pick_ch   = slot_channel(pick_slot, cfg_q.user_seq, user_seq_in);
    wire            pick_ok   = pick_found && (pick_ch < CH_W'(NUM_CH));
    wire            cnt_zero  = (cnt_q == '0);
    wire [CNT_W-1:0] wake_cnt = (cfg_q.pwr_mode == PWR_STANDBY) ?
                                CNT_W'(STANDBY_CYCLES) : CNT_W'(STARTUP_CYCLES);

    // ==========================================================
    // sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                // triggers seen only here, so a running sequence ignores them
                if (trig_hit) begin
                    state_d = (cfg_q.pwr_mode == PWR_FULL) ? ST_PICK : ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (cnt_zero) begin
                    state_d = ST_PICK;
                end
            end
            ST_PICK: state_d = pick_ok ? ST_CONV : ST_DONE;
            // fixed conversion length whatever the resolution
            ST_CONV: begin
                if (cnt_zero && cell_done_in) begin
                    state_d = ST_PICK;
                end
            end
            ST_DONE: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state_q  <= ST_IDLE;
            slot_q   <= '0;
            cur_ch_q <= '0;
            cnt_q    <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_IDLE) begin
                slot_q <= '0;
                cnt_q  <= wake_cnt;
            end else if (state_q == ST_PICK && pick_ok) begin
                cur_ch_q <= pick_ch;
                slot_q   <= pick_slot + CH_W'(1);
                cnt_q    <= CNT_W'(CONVERT_CYCLES - 1);
            end else if (!cnt_zero) begin
                cnt_q <= cnt_q - CNT_W'(1);
            end
        end
    end

    wire in_conv    = (state_q == ST_CONV);
    wire conv_done  = in_conv && cnt_zero && cell_done_in;
    // low-res drops two lsbs and right-aligns, upper bits zero
    wire [RES_W-1:0] res_val = cfg_q.low_res ?
        {{(RES_W-LOW_W){1'b0}}, cell_data_in[RES_W-1 -: LOW_W]} : cell_data_in;

    // ==========================================================
    // results and flags
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < NUM_CH; i++) begin
                chan_q[i] <= '0;
            end
            last_q    <= '0;
            last_ch_q <= '0;
        end else if (conv_done) begin
            chan_q[cur_ch_q] <= res_val;
            last_q           <= res_val;
            last_ch_q        <= cur_ch_q;
        end
    end

    // set wins over a clearing read in the same cycle
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            eoc_q   <= '0;
            ready_q <= 1'b0;
            ovr_q   <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (conv_done && cur_ch_q == CH_W'(i)) begin
                    eoc_q[i] <= 1'b1;
                end else if (rd_channel_in && rd_channel_idx_in == CH_W'(i)) begin
                    eoc_q[i] <= 1'b0;
                end
            end
            if (conv_done) begin
                ready_q <= 1'b1;
            end else if (rd_last_in) begin
                ready_q <= 1'b0;
            end
            if (conv_done && ready_q && !rd_last_in) begin
                ovr_q <= 1'b1;
            end else if (rd_status_in) begin
                ovr_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // window comparison
    logic cmp_now;
    always_comb begin
        unique case (cfg_q.cmp_mode)
            CMP_LOW:     cmp_now = res_val < cfg_q.cmp_low;
            CMP_HIGH:    cmp_now = res_val > cfg_q.cmp_high;
            CMP_INSIDE:  cmp_now = (res_val >= cfg_q.cmp_low) && (res_val <= cfg_q.cmp_high);
            CMP_OUTSIDE: cmp_now = (res_val < cfg_q.cmp_low) || (res_val > cfg_q.cmp_high);
            default:     cmp_now = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            hit_q <= 1'b0;
        end else if (conv_done && cmp_now) begin
            hit_q <= 1'b1;
        end else if (rd_status_in) begin
            hit_q <= 1'b0;
        end
    end

    // ==========================================================
    // touchscreen averaging over 2^avg_shift samples of channel 0
    // 5-wire panels have no pressure path, so only channel 0 averaged
    wire [3:0] avg_n  = 4'(1 << cfg_q.avg_shift);
    wire       t_samp = conv_done && (cfg_q.panel != PANEL_NONE) && (cur_ch_q == '0);
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            acc_q    <= '0;
            acc_n_q  <= '0;
            tavg_q   <= '0;
            tvalid_q <= 1'b0;
        end else begin
            tvalid_q <= 1'b0;
            if (t_samp) begin
                if (acc_n_q + 4'h1 >= avg_n) begin
                    tavg_q   <= RES_W'((acc_q + (RES_W+3)'(res_val)) >> cfg_q.avg_shift);
                    tvalid_q <= 1'b1;
                    acc_q    <= '0;
                    acc_n_q  <= '0;
                end else begin
                    acc_q   <= acc_q + (RES_W+3)'(res_val);
                    acc_n_q <= acc_n_q + 4'h1;
                end
            end
        end
    end

    // ==========================================================
    // outputs
    assign cell_start_out      = (state_q == ST_PICK) && pick_ok;
    assign mux_sel_out         = cur_ch_q;
    assign mux_route_out       = in_conv && ch_live[cur_ch_q];
    assign cell_power_out      = (cfg_q.pwr_mode == PWR_FULL) || (state_q != ST_IDLE);
    assign cell_bias_out       = cell_power_out || (cfg_q.pwr_mode == PWR_STANDBY);
    assign last_result_out     = last_q;
    assign last_channel_out    = last_ch_q;
    for (genvar g = 0; g < NUM_CH; g++) begin : g_res
        assign channel_result_out[g*RES_W +: RES_W] = chan_q[g];
    end
    assign eoc_out             = eoc_q;
    assign result_ready_flag   = ready_q;
    assign global_overrun_flag = ovr_q;
    assign compare_hit_out     = hit_q;
    assign touch_avg_out       = tavg_q;
    assign touch_valid_out     = tvalid_q;
    assign busy_out            = (state_q != ST_IDLE);
    assign irq_out             = ready_q || ovr_q || hit_q;

    // ==========================================================
    // checks
    AST_OVR_SET: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (conv_done && ready_q && !rd_last_in) |=> ovr_q)
        else $error("overrun not raised");
    AST_READY_SET: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        conv_done |=> ready_q && eoc_q[$past(cur_ch_q)])
        else $error("ready or eoc not set");
    AST_LAST_CLR: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (rd_last_in && !conv_done) |=> !ready_q)
        else $error("ready not cleared by read");
    AST_REDUCED_RESOLUTION_SELECT: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (conv_done && cfg_q.low_res) |=> last_q[RES_W-1:LOW_W] == '0)
        else $error("low-res upper bits not zero");
    AST_IGNORE_TRIG: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (state_q == ST_CONV) |=> state_q inside {ST_CONV, ST_PICK})
        else $error("sequence disturbed");
    AST_PROTECT: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        protect_in |=> cfg_q == $past(cfg_q))
        else $error("protected config changed");
    AST_SLEEP_WAKE: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (state_q == ST_IDLE && trig_hit && cfg_q.pwr_mode != PWR_FULL)
        |=> ##[0:1000] state_q == ST_PICK)
        else $error("sleep wake too slow");
    AST_PIN_EDGE: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (state_q == ST_IDLE && pin_rise && cfg_q.trig_src == TRG_EXT_PIN) |=> state_q != ST_IDLE)
        else $error("pin edge did not start a sequence");
    AST_ROUTE: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        mux_route_out |-> ch_enable_in[mux_sel_out] && !digital_sel_in[mux_sel_out])
        else $error("routed disabled input");

endmodule
`default_nettype wire

// [adc_cell_model.sv]
// behavioural converter cell answering each start after a fixed delay
`timescale 1ns/1ns
`default_nettype none
module adc_cell_model
    import adc_ctrl_pkg::*;
#(
    parameter int LATENCY = 2
) (
    input  wire logic              clk_in,
    input  wire logic              reset_n_in,
    input  wire logic              start_in,
    input  wire logic [CH_W-1:0]   sel_in,
    output logic                   done_out,
    output logic [RES_W-1:0]       data_out
);
    int cnt;

    // ==========================================================
    // conversion timing
    // data toggles while not done, so a stale sample never looks valid
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            cnt <= 0;
            done_out <= 1'b0;
            data_out <= '0;
        end else if (start_in) begin
            cnt <= LATENCY;
            done_out <= 1'b0;
            data_out <= ~data_out;
        end else if (cnt == 1) begin
            cnt <= 0;
            done_out <= 1'b1;
            data_out <= {sel_in, 6'h2a};
        end else if (!done_out) begin
            cnt <= (cnt > 0) ? cnt - 1 : 0;
            data_out <= ~data_out;
        end
    end
endmodule
`default_nettype wire

// [test_adc_conversion_controller.sv]
// self-checking bench for the conversion controller
`timescale 1ns/1ns
`default_nettype none
module test_adc_conversion_controller
    import adc_ctrl_pkg::*;
;
    logic                    clk_in, reset_n_in, cfg_we_in, protect_in, sw_start_in, ext_pin;
    logic                    rd_channel_in, rd_last_in, rd_status_in, cell_done, cell_start;
    logic                    ready, ovr, hit, busy, irq;
    adc_cfg_s                cfg, c;
    logic [NUM_CH-1:0]       ch_en, dig_sel, eoc;
    logic [NUM_TIMER-1:0]    timer_trig;
    logic [CH_W-1:0]         rd_idx, mux_sel, last_ch;
    logic [RES_W-1:0]        cell_data, last_res;
    logic [NUM_CH*RES_W-1:0] ch_res;
    int                      miscompares, n_checks, cyc_a, cyc_b;
    logic                    pen, power, bias, route, t_valid;
    logic [NUM_CH*CH_W-1:0]  useq;
    logic [RES_W-1:0]        t_avg, t_val;
    logic [NUM_CH-1:0]       route_seen = '0;
    int                      t_cnt = 0;

    // ==========================================================
    // instances
    // short counts keep each sequence to 12 cycles or fewer
    adc_conversion_controller #(.STARTUP_CYCLES(2), .STANDBY_CYCLES(2), .CONVERT_CYCLES(4)) u_dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .cfg_in(cfg), .cfg_we_in(cfg_we_in),
        .protect_in(protect_in), .ch_enable_in(ch_en), .digital_sel_in(dig_sel),
        .user_seq_in(useq), .sw_start_in(sw_start_in),
        .external_trigger_pin(ext_pin), .timer_trig_in(timer_trig), .pen_contact_in(pen),
        .rd_channel_in(rd_channel_in), .rd_channel_idx_in(rd_idx), .rd_last_in(rd_last_in),
        .rd_status_in(rd_status_in), .cell_done_in(cell_done), .cell_data_in(cell_data),
        .cell_start_out(cell_start), .mux_sel_out(mux_sel), .mux_route_out(route),
        .cell_power_out(power), .cell_bias_out(bias), .last_result_out(last_res),
        .last_channel_out(last_ch), .channel_result_out(ch_res), .eoc_out(eoc),
        .result_ready_flag(ready), .global_overrun_flag(ovr), .compare_hit_out(hit),
        .touch_avg_out(t_avg), .touch_valid_out(t_valid), .busy_out(busy), .irq_out(irq));
    adc_cell_model u_cell (.clk_in(clk_in), .reset_n_in(reset_n_in), .start_in(cell_start),
        .sel_in(mux_sel), .done_out(cell_done), .data_out(cell_data));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // ==========================================================
    // monitor
    // touch pulses stand one cycle and route only during conversion, so catch them mid-cycle
    always @(negedge clk_in) begin
        if (route) begin
            route_seen[mux_sel] <= 1'b1;
        end
        if (t_valid) begin
            t_cnt <= t_cnt + 1;
            t_val <= t_avg;
        end
    end

    // ==========================================================
    // helpers
    function automatic logic [RES_W-1:0] exp_data(input int ch);
        return {ch[3:0], 6'h2a};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic set_cfg(input adc_cfg_s v, input logic prot);
        @(negedge clk_in);
        cfg = v;
        protect_in = prot;
        cfg_we_in = 1'b1;
        @(negedge clk_in);
        cfg_we_in = 1'b0;
        protect_in = 1'b0;
    endtask

    // which: 0 channel read, 1 last-result read, 2 status read
    task automatic strobe(input int which, input int idx);
        @(negedge clk_in);
        rd_idx = idx[CH_W-1:0];
        rd_channel_in = (which == 0);
        rd_last_in = (which == 1);
        rd_status_in = (which == 2);
        @(negedge clk_in);
        {rd_channel_in, rd_last_in, rd_status_in} = 3'b000;
    endtask

    // src: 0 software, 1 pin, 2 timer line 1, 3 pen; returns busy length in cycles
    task automatic run(input int src, output int cycles);
        int n;
        n = 0;
        cycles = 0;
        @(negedge clk_in);
        sw_start_in = (src == 0);
        ext_pin = (src == 1);
        timer_trig[1] = (src == 2);
        pen = (src == 3);
        while (busy !== 1'b1 && n < 20) begin
            @(negedge clk_in);
            sw_start_in = 1'b0;
            n++;
        end
        ext_pin = 1'b0;
        timer_trig = '0;
        pen = 1'b0;
        while (busy !== 1'b0 && cycles < 500) begin
            @(negedge clk_in);
            cycles++;
        end
        if (n >= 20 || cycles >= 500) begin
            miscompares++;
            $display("wrong value at %0t: sequence did not complete", $time);
            summarize();
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        {reset_n_in, cfg_we_in, protect_in, sw_start_in, ext_pin} = '0;
        {rd_channel_in, rd_last_in, rd_status_in, rd_idx, timer_trig} = '0;
        {ch_en, dig_sel, miscompares, n_checks} = '0;
        cfg = '0;
        c = '0;
        {pen, useq} = '0;
        repeat (16) @(negedge clk_in);
        reset_n_in = 1'b1;
        set_cfg(c, 1'b0);
        ch_en = 12'h024;
        run(0, cyc_a);
        chk(ch_res[20 +: 10], exp_data(2), "ch2 result");
        chk(ch_res[50 +: 10], exp_data(5), "ch5 result");
        chk(ch_res[30 +: 10], '0, "ch3 untouched");
        chk(last_res, exp_data(5), "last result");
        chk(last_ch, 16'h5, "last channel");
        chk(eoc, 16'h024, "eoc");
        chk({ready, ovr, irq}, 16'h7, "flags");
        strobe(2, 0);
        chk(ovr, 16'h0, "overrun cleared");
        strobe(0, 2);
        chk(eoc, 16'h020, "eoc after read");
        strobe(1, 0);
        chk({ready, irq}, 16'h0, "ready cleared");
        ch_en = 12'h801;
        dig_sel = 12'h800;
        run(0, cyc_b);
        chk(eoc, 16'h021, "digital pin skipped");
        chk({last_ch, ready, ovr}, 16'h2, "single result");
        strobe(1, 0);
        dig_sel = '0;
        c.low_res = 1'b1;
        set_cfg(c, 1'b1);
        ch_en = 12'h008;
        run(0, cyc_a);
        chk(last_res, exp_data(3), "protected write");
        strobe(1, 0);
        c.trig_src = TRG_EXT_PIN;
        c.cmp_mode = CMP_INSIDE;
        c.cmp_high = 10'h3ff;
        set_cfg(c, 1'b0);
        run(1, cyc_b);
        chk(last_res, {2'b00, exp_data(3) >> 2}, "reduced");
        chk(ch_res[30 +: 10], {2'b00, exp_data(3) >> 2}, "reduced ch3");
        chk(cyc_b, cyc_a, "reduced timing");
        chk(hit, 16'h1, "window hit");
        strobe(2, 0);
        chk(hit, 16'h0, "hit cleared");
        strobe(1, 0);
        c.trig_src = TRG_TIMER;
        c.timer_sel = 2'h1;
        set_cfg(c, 1'b0);
        timer_trig = 3'b101;
        ext_pin = 1'b1;
        repeat (6) @(negedge clk_in);
        chk(busy, 16'h0, "unselected sources");
        timer_trig = '0;
        ext_pin = 1'b0;
        run(2, cyc_b);
        chk({last_ch, ready}, 16'h7, "timer start");
        strobe(1, 0);
        c.pwr_mode = PWR_SLEEP;
        set_cfg(c, 1'b0);
        chk({power, bias}, 16'h0, "asleep while idle");
        run(0, cyc_b);
        // startup count of 2 plus the cycle that sees it reach zero
        chk(cyc_b, cyc_a + 3, "startup wait");
        chk({power, last_ch}, 16'h3, "asleep again");
        c.pwr_mode = PWR_STANDBY;
        set_cfg(c, 1'b0);
        chk({power, bias}, 16'h1, "standby bias");
        c.pwr_mode = PWR_FULL;
        c.trig_src = TRG_PEN;
        c.panel = PANEL_4WIRE;
        c.avg_shift = 2'h1;
        c.low_res = 1'b0;
        c.cmp_mode = CMP_HIGH;
        set_cfg(c, 1'b0);
        strobe(2, 0);
        ch_en = 12'h001;
        run(3, cyc_b);
        chk(t_cnt, 16'h0, "one sample no average");
        run(3, cyc_b);
        chk({t_cnt[3:0], t_val}, {4'h1, exp_data(0)}, "touch average");
        chk(hit, 16'h0, "high bound not crossed");
        c.user_seq = 1'b1;
        set_cfg(c, 1'b0);
        ch_en = 12'h030;
        useq = 48'h000000450000;
        run(0, cyc_b);
        chk({last_ch, ch_res[40 +: 10]}, {4'h4, exp_data(4)}, "custom order");
        chk(route_seen, 16'h03d, "routed inputs");
        summarize();
    end
endmodule
`default_nettype wire
